// ### verilog/msr_mode_seq.sv
`timescale 1ns/1ps
module msr_mode_seq
    import msr_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire msr_pkg::msr_evt_type evt,
    input  wire logic                resetButton,
    input  wire logic                resetInput,
    input  wire logic                alarmResetEnable,
    input  wire logic [NUM_OUT-1:0]  logicOutputs,
    input  wire msr_pkg::msr_mon_type mon,
    output logic [3:0]               displayCode,
    output logic [NUM_OUT-1:0]       safeOutputs,
    output logic [NUM_MON-1:0]       monTrip,
    output logic                     logicClear,
    output logic                     busInitReq,
    output logic                     loadEnable,
    output logic                     syncActive,
    output logic                     cfgActive
);
    import msr_pkg::*;

    typedef struct packed {
        msr_mode_type mode;
        logic [3:0] disp;
        logic [NUM_OUT-1:0] outs;
        logic [NUM_MON-1:0] trip;
        logic clr;
        logic busReq;
        logic loadEn;
        logic syncAct;
        logic cfgAct;
    } msr_state_type;

    msr_state_type s;
    msr_state_type next_s;
    logic          operatorReset;

    msr_reset_detect u_rdet (
        .mclk             (mclk),
        .rst_n            (rst_n),
        .resetButton      (resetButton),
        .resetInput       (resetInput),
        .alarmResetEnable (alarmResetEnable),
        .runMode          (s.mode == ST_RUN),
        .operatorReset    (operatorReset)
    );

    function automatic logic [3:0] modeCode(input msr_mode_type m);
        case (m)
            ST_SYNC:   modeCode = DISP_SYNC;
            ST_CFG:    modeCode = DISP_CFG;
            ST_BUS:    modeCode = DISP_BUS;
            ST_RUN:    modeCode = DISP_RUN;
            ST_LOAD:   modeCode = DISP_LOAD;
            ST_ALARM:  modeCode = DISP_ALARM;
            ST_SALARM: modeCode = DISP_SALARM;
            default:   modeCode = DISP_FATAL;
        endcase
    endfunction

    logic opClear;
    assign opClear = operatorReset && (s.mode != ST_FATAL);

    always_comb
    begin
        next_s = s;
        next_s.clr = opClear;
        case (s.mode)
            ST_SYNC:
            begin
                if (evt.syncFail)
                    next_s.mode = ST_FATAL;
                else if (evt.syncDone)
                    next_s.mode = ST_CFG;
            end
            ST_CFG:
            begin
                if (evt.cfgFail)
                    next_s.mode = ST_FATAL;
                else if (evt.cfgDone)
                    next_s.mode = ST_BUS;
            end
            ST_BUS:
            begin
                if (evt.busPresent && evt.busFail)
                    next_s.mode = ST_FATAL;
                else if (!evt.busPresent || evt.busDone)
                    next_s.mode = ST_RUN;
            end
            ST_RUN:
            begin
                if (evt.fatalEvt)
                    next_s.mode = ST_FATAL;
                else if (evt.alarmEvt)
                    next_s.mode = ST_ALARM;
                else if (evt.salarmEvt)
                    next_s.mode = ST_SALARM;
                else if (evt.loadReq)
                    next_s.mode = ST_LOAD;
            end
            ST_LOAD:
            begin
                if (evt.fatalEvt)
                    next_s.mode = ST_FATAL;
                else if (evt.loadDone)
                    next_s.mode = ST_SYNC;
            end
            ST_ALARM:
            begin
                // fatal outranks a reset arriving in the same cycle
                if (evt.fatalEvt)
                    next_s.mode = ST_FATAL;
                else if (opClear)
                    next_s.mode = ST_RUN;
            end
            ST_SALARM:
            begin
                if (evt.fatalEvt)
                    next_s.mode = ST_FATAL;
                else if (opClear)
                    next_s.mode = ST_RUN;
            end
            ST_FATAL:
                next_s.mode = ST_FATAL;
            default:
                next_s.mode = ST_FATAL;
        endcase

        // on a reset, process monitors reload from the live limit inputs and time monitors clear
        for (int i = 0; i < NUM_MON; i++)
        begin
            if (opClear)
                next_s.trip[i] = mon.timeBased[i] ? 1'b0 : mon.limitHit[i];
            else if (mon.timeBased[i] ? mon.timeExpired[i] : mon.limitHit[i])
                next_s.trip[i] = 1'b1;
            else if (!mon.timeBased[i])
                next_s.trip[i] = 1'b0;
        end

        next_s.disp    = modeCode(next_s.mode);
        next_s.outs    = (next_s.mode == ST_RUN && !opClear) ? logicOutputs : '0;
        next_s.busReq  = (next_s.mode == ST_BUS) && evt.busPresent;
        next_s.loadEn  = (next_s.mode == ST_LOAD);
        next_s.syncAct = (next_s.mode == ST_SYNC);
        next_s.cfgAct  = (next_s.mode == ST_CFG);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            // power-on clear: the only path out of fatal error
            s <= '{mode: ST_SYNC, disp: DISP_SYNC, default: '0};
        end
        else
            s <= next_s;
    end

    assign displayCode = s.disp;
    assign safeOutputs = s.outs;
    assign monTrip     = s.trip;
    assign logicClear  = s.clr;
    assign busInitReq  = s.busReq;
    assign loadEnable  = s.loadEn;
    assign syncActive  = s.syncAct;
    assign cfgActive   = s.cfgAct;

    sequence s_fatal_held;
        s.mode == ST_FATAL;
    endsequence

    property p_fatal_sticky;
        @(posedge mclk) disable iff (!rst_n)
        s_fatal_held |=> s_fatal_held;
    endproperty
    a_fatal_sticky: assert property (p_fatal_sticky)
        else $error("fatal error state left without power cycle");

    property p_passive_outputs;
        @(posedge mclk) disable iff (!rst_n)
        (s.mode != ST_RUN) |-> (safeOutputs == '0);
    endproperty
    a_passive_outputs: assert property (p_passive_outputs)
        else $error("outputs active outside run");

    property p_run_outputs;
        @(posedge mclk) disable iff (!rst_n)
        (next_s.mode == ST_RUN && !opClear) |=> (safeOutputs == $past(logicOutputs));
    endproperty
    a_run_outputs: assert property (p_run_outputs)
        else $error("run outputs do not follow logic");

    property p_alarm_clear;
        @(posedge mclk) disable iff (!rst_n)
        (s.mode == ST_ALARM && operatorReset && !evt.fatalEvt) |=> (s.mode == ST_RUN);
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("alarm not cleared by operator reset");

    property p_salarm_clear;
        @(posedge mclk) disable iff (!rst_n)
        (s.mode == ST_SALARM && operatorReset && !evt.fatalEvt) |=> (s.mode == ST_RUN);
    endproperty
    a_salarm_clear: assert property (p_salarm_clear)
        else $error("secondary alarm not cleared by operator reset");

    property p_processor_sync_phase_order;
        @(posedge mclk) disable iff (!rst_n)
        (s.mode == ST_CFG) |-> ($past(s.mode) inside {ST_SYNC, ST_CFG});
    endproperty
    a_processor_sync_phase_order: assert property (p_processor_sync_phase_order)
        else $error("config phase entered out of order");

    property p_display_code;
        @(posedge mclk) disable iff (!rst_n)
        ##1 (displayCode == modeCode(s.mode));
    endproperty
    a_display_code: assert property (p_display_code)
        else $error("display code does not match mode");

    property p_time_monitor_reset;
        @(posedge mclk) disable iff (!rst_n)
        opClear |=> ((monTrip & $past(mon.timeBased)) == '0);
    endproperty
    a_time_monitor_reset: assert property (p_time_monitor_reset)
        else $error("time monitor not returned to initial state");

    property p_process_monitor_hold;
        @(posedge mclk) disable iff (!rst_n)
        opClear |=> ((monTrip & ~$past(mon.timeBased)) ==
                     ($past(mon.limitHit) & ~$past(mon.timeBased)));
    endproperty
    a_process_monitor_hold: assert property (p_process_monitor_hold)
        else $error("process monitor output changed on reset");

    property p_clear_pulse;
        @(posedge mclk) disable iff (!rst_n)
        opClear |=> logicClear;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse)
        else $error("operator reset did not clear logic");

endmodule

// ### verilog/msr_pkg.sv
package msr_pkg;

    // 7-segment display codes per mode
    localparam logic [3:0] DISP_SYNC   = 4'h1;
    localparam logic [3:0] DISP_CFG    = 4'h2;
    localparam logic [3:0] DISP_BUS    = 4'h3;
    localparam logic [3:0] DISP_RUN    = 4'h4;
    localparam logic [3:0] DISP_LOAD   = 4'h5;
    localparam logic [3:0] DISP_ALARM  = 4'ha;
    localparam logic [3:0] DISP_SALARM = 4'he;
    localparam logic [3:0] DISP_FATAL  = 4'hf;

    localparam int CLK_HZ          = 25000000;
    localparam int PULSE_LIMIT_MS  = 3000;
    localparam longint PULSE_LIMIT_CYC_L = longint'(PULSE_LIMIT_MS) * longint'(CLK_HZ) / 1000;
    localparam int PULSE_LIMIT_CYC = int'(PULSE_LIMIT_CYC_L);
    localparam int PCNT_W          = 27;

    localparam int NUM_OUT = 8;
    localparam int NUM_MON = 4;

    typedef enum logic [7:0] {
        ST_SYNC   = 8'h01,
        ST_CFG    = 8'h02,
        ST_BUS    = 8'h04,
        ST_RUN    = 8'h08,
        ST_LOAD   = 8'h10,
        ST_ALARM  = 8'h20,
        ST_SALARM = 8'h40,
        ST_FATAL  = 8'h80
    } msr_mode_type;

    // phase handshakes from the two processor systems
    typedef struct packed {
        logic syncDone;
        logic syncFail;
        logic cfgDone;
        logic cfgFail;
        logic busPresent;
        logic busDone;
        logic busFail;
        logic loadReq;
        logic loadDone;
        logic alarmEvt;
        logic salarmEvt;
        logic fatalEvt;
    } msr_evt_type;

    // per-monitor inputs: kind, limit exceeded, time-limit elapsed
    typedef struct packed {
        logic [NUM_MON-1:0] timeBased;
        logic [NUM_MON-1:0] limitHit;
        logic [NUM_MON-1:0] timeExpired;
    } msr_mon_type;

    typedef struct packed {
        logic [2:0] btnSync;
        logic [2:0] rinSync;
        logic [PCNT_W-1:0] pulseCnt;
        logic pulseLong;
    } msr_rdet_type;

endpackage

// ### verilog/msr_reset_detect.sv
`timescale 1ns/1ps
module msr_reset_detect
    import msr_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic resetButton,
    input  wire logic resetInput,
    input  wire logic alarmResetEnable,
    input  wire logic runMode,
    output logic      operatorReset
);
    import msr_pkg::*;

    msr_rdet_type r;
    msr_rdet_type next_r;
    logic         next_operatorReset;

    logic btnRise;
    logic rinRise;
    logic rinFall;

    // bit 0 is the first sync stage; only bit 1 reads it
    assign btnRise = r.btnSync[1] & ~r.btnSync[2];
    assign rinRise = r.rinSync[1] & ~r.rinSync[2];
    assign rinFall = ~r.rinSync[1] & r.rinSync[2];

    always_comb
    begin
        next_r = r;
        next_r.btnSync = {r.btnSync[1:0], resetButton};
        next_r.rinSync = {r.rinSync[1:0], resetInput};
        if (rinRise)
        begin
            next_r.pulseCnt = '0;
            next_r.pulseLong = 1'b0;
        end
        else if (r.rinSync[2] && !r.pulseLong)
        begin
            if (r.pulseCnt >= PCNT_W'(PULSE_LIMIT_CYC - 1))
                next_r.pulseLong = 1'b1;
            else
                next_r.pulseCnt = r.pulseCnt + PCNT_W'(1);
        end
        next_operatorReset = btnRise;
        if (alarmResetEnable && rinFall)
        begin
            // outside run the input is not time monitored
            if (!runMode || !r.pulseLong)
                next_operatorReset = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            r <= '0;
            operatorReset <= 1'b0;
        end
        else
        begin
            r <= next_r;
            operatorReset <= next_operatorReset;
        end
    end

    property p_long_pulse_no_reset;
        @(posedge mclk) disable iff (!rst_n)
        (runMode && r.pulseLong && rinFall && !btnRise) |=> !operatorReset;
    endproperty
    a_long_pulse_no_reset: assert property (p_long_pulse_no_reset)
        else $error("long reset pulse produced operator reset");

    property p_short_pulse_reset;
        @(posedge mclk) disable iff (!rst_n)
        (alarmResetEnable && !r.pulseLong && rinFall) |=> operatorReset;
    endproperty
    a_short_pulse_reset: assert property (p_short_pulse_reset)
        else $error("short reset pulse gave no operator reset");

    property p_button_reset;
        @(posedge mclk) disable iff (!rst_n)
        btnRise |=> operatorReset;
    endproperty
    a_button_reset: assert property (p_button_reset)
        else $error("button press gave no operator reset");

endmodule

// ### bench/msr_operator_model.sv
`timescale 1ns/1ps
module msr_operator_model (
    input  wire logic mclk,
    output logic      resetButton,
    output logic      resetInput
);
    initial
    begin
        resetButton = 1'b0;
        resetInput  = 1'b0;
    end

    // both lines are actuated by a person: high for whole cycles, idle low otherwise
    task automatic press_button(input int hold);
        @(negedge mclk);
        resetButton = 1'b1;
        repeat (hold) @(negedge mclk);
        resetButton = 1'b0;
    endtask

    // high time is what the run-mode width check judges; release is the trigger edge
    task automatic pulse_input(input int hold);
        @(negedge mclk);
        resetInput = 1'b1;
        repeat (hold) @(negedge mclk);
        resetInput = 1'b0;
    endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import msr_pkg::*;
    typedef struct packed {
        logic [11:0] ev;
        logic [3:0]  code;
        logic [3:0]  flags;
        logic        run;
    } msr_tb_row_type;
    logic                mclk = 1'b0;
    logic                rst_n;
    msr_evt_type         evt;
    logic                resetButton;
    logic                resetInput;
    logic                alarmResetEnable;
    logic [NUM_OUT-1:0]  logicOutputs;
    msr_mon_type         mon;
    logic [3:0]          displayCode;
    logic [NUM_OUT-1:0]  safeOutputs;
    logic [NUM_MON-1:0]  monTrip;
    logic                logicClear;
    logic                busInitReq;
    logic                loadEnable;
    logic                syncActive;
    logic                cfgActive;
    int                  errors = 0;
    int                  checksDone = 0;
    logic                seen;
    msr_tb_row_type      rows [11];

    always #20 mclk = ~mclk;

    msr_operator_model u_msr_operator_model (.mclk(mclk), .resetButton(resetButton),
        .resetInput(resetInput));
    msr_mode_seq u_msr_mode_seq (.mclk(mclk), .rst_n(rst_n), .evt(evt),
        .resetButton(resetButton), .resetInput(resetInput),
        .alarmResetEnable(alarmResetEnable), .logicOutputs(logicOutputs), .mon(mon),
        .displayCode(displayCode), .safeOutputs(safeOutputs), .monTrip(monTrip),
        .logicClear(logicClear), .busInitReq(busInitReq), .loadEnable(loadEnable),
        .syncActive(syncActive), .cfgActive(cfgActive));

    task automatic complete_run();
        $display("errors %0d checks %0d", errors, checksDone);
        if (errors == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bad(input string what);
        errors++;
        $display("BAD %0t %s", $time, what);
    endtask

    task automatic check_code(input logic [3:0] got, input logic [3:0] exp, input string what);
        checksDone++;
        if (got !== exp)
            bad(what);
    endtask

    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
        checksDone++;
        if (got !== exp)
            bad(what);
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        checksDone++;
        if (got !== exp)
            bad(what);
    endtask

    // one-edge event, entered and left at a falling edge
    task automatic pulse_evt(input logic [11:0] ev);
        evt = ev;
        @(negedge mclk);
        evt = '0;
    endtask

    // the clear strobe stands one cycle, so it is looked for at every falling edge
    task automatic wait_clear(output logic hit);
        hit = 1'b0;
        repeat (12)
        begin
            @(negedge mclk);
            if (logicClear === 1'b1 && hit === 1'b0)
                hit = 1'b1;
            if (hit === 1'b1)
                break;
        end
    endtask

    initial
    begin
        rst_n            = 1'b0;
        evt              = '0;
        alarmResetEnable = 1'b0;
        logicOutputs     = 8'h5a;
        mon              = '0;
        // event, expected code, {sync,cfg,busInit,load}, outputs live
        rows[0]  = '{12'h800, 4'h2, 4'h4, 1'b0};
        rows[1]  = '{12'h280, 4'h3, 4'h2, 1'b0};
        rows[2]  = '{12'h080, 4'h3, 4'h2, 1'b0};
        rows[3]  = '{12'h0c0, 4'h4, 4'h0, 1'b1};
        rows[4]  = '{12'h000, 4'h4, 4'h0, 1'b1};
        rows[5]  = '{12'h010, 4'h5, 4'h1, 1'b0};
        rows[6]  = '{12'h008, 4'h1, 4'h8, 1'b0};
        rows[7]  = '{12'h800, 4'h2, 4'h4, 1'b0};
        rows[8]  = '{12'h200, 4'h3, 4'h0, 1'b0};
        rows[9]  = '{12'h000, 4'h4, 4'h0, 1'b1};
        rows[10] = '{12'h002, 4'he, 4'h0, 1'b0};
        repeat (3) @(negedge mclk);
        check_code(displayCode, DISP_SYNC, "code in reset");
        rst_n = 1'b1;
        @(negedge mclk);
        check_flag(syncActive, 1'b1, "sync phase");
        foreach (rows[i])
        begin
            evt = rows[i].ev;
            @(negedge mclk);
            check_code(displayCode, rows[i].code, "mode code");
            check_code({syncActive, cfgActive, busInitReq, loadEnable}, rows[i].flags,
                "phase flags");
            check_vec(safeOutputs, rows[i].run ? logicOutputs : 8'h00, "outputs");
        end
        evt = '0;
        fork
            u_msr_operator_model.press_button(2);
            wait_clear(seen);
        join
        check_flag(seen, 1'b1, "clear from button");
        check_code(displayCode, DISP_RUN, "leave second alarm");
        @(negedge mclk);
        check_vec(safeOutputs, logicOutputs, "outputs after clear");
        logicOutputs = 8'ha5;
        @(negedge mclk);
        check_vec(safeOutputs, 8'ha5, "outputs follow logic");
        pulse_evt(12'h004);
        check_code(displayCode, DISP_ALARM, "alarm code");
        check_vec(safeOutputs, 8'h00, "alarm outputs");
        alarmResetEnable = 1'b1;
        fork
            u_msr_operator_model.pulse_input(4);
            wait_clear(seen);
        join
        check_flag(seen, 1'b1, "clear from input");
        check_code(displayCode, DISP_RUN, "leave alarm");
        fork
            u_msr_operator_model.pulse_input(5);
            wait_clear(seen);
        join
        check_flag(seen, 1'b1, "short pulse in run");
        alarmResetEnable = 1'b0;
        fork
            u_msr_operator_model.pulse_input(5);
            wait_clear(seen);
        join
        check_flag(seen, 1'b0, "input without alarm reset");
        mon = '{4'h3, 4'h5, 4'h3};
        repeat (2) @(negedge mclk);
        check_code(monTrip, 4'h7, "monitors tripped");
        mon.timeExpired = 4'h0;
        fork
            u_msr_operator_model.press_button(2);
            wait_clear(seen);
        join
        repeat (2) @(negedge mclk);
        check_code(monTrip, 4'h4, "monitors rebuilt");
        mon = '0;
        pulse_evt(12'h005);
        check_code(displayCode, DISP_FATAL, "fatal wins");
        fork
            u_msr_operator_model.press_button(2);
            wait_clear(seen);
        join
        check_flag(seen, 1'b0, "fatal ignores reset");
        check_code(displayCode, DISP_FATAL, "fatal held");
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        check_code(displayCode, DISP_SYNC, "power-on clear");
        pulse_evt(12'h400);
        check_code(displayCode, DISP_FATAL, "failed check");
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        pulse_evt(12'h800);
        pulse_evt(12'h100);
        check_code(displayCode, DISP_FATAL, "failed config check");
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        pulse_evt(12'h800);
        pulse_evt(12'h200);
        pulse_evt(12'h0a0);
        check_code(displayCode, DISP_FATAL, "failed bus init");
        complete_run();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        errors++;
        complete_run();
    end
endmodule
